// >>> ep_zero_interrupt_status.v
// What this block does
// - any unmasked status bit being set raises shared request
// - status register is read only, 8-bit
// - writing 0 to clear bit clears status
// - next SETUP clears success and stage flags
// - all USB sources ORed into one request
// - request stays high while any source pending
// - bit 6 set on NAKed endpoint-zero IN
// - bit 5 set when host got transmit data
// - data sent on IN after arming one
// - bit 5 set for null packet too
// - first transmit-buffer write clears bit 5
// - bit 4 on receive data, not null
// - bit 3 when status stage completes correctly
// - bit 2 when entering status stage
// - bit 0 decode pending, bit 1 setup
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ep_zero_irq_consts.vh"

module ep_zero_interrupt_status #(
  parameter ADDR_W = 24
) (
  input wire REF_CLK,
  input wire RST_B,
  input wire [ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire IN_TOKEN,
  input wire TX_DONE_EVT,
  input wire TX_BUF_WRITE,
  input wire RX_DATA_EVT,
  input wire RX_IS_NULL,
  input wire RX_EMPTIED,
  input wire STATUS_OK_EVT,
  input wire STATUS_STAGE_EVT,
  input wire SETUP_TOKEN,
  input wire SETUP_DATA_EVT,
  input wire FW_DECODE_EVT,
  input wire SETUP_BUF_READ_DONE,
  input wire [7:0] BUS_EVT,
  output reg TX_SEND,
  output reg IN_NAK,
  output reg USB_SHARED_IRQ
);

  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // address to register index, or all ones when not word aligned
  function [21:0] word_index;
    input [ADDR_W-1:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        word_index = 22'h3FFFFF;
      end else begin
        word_index = addr[ADDR_W-1:2];
      end
    end
  endfunction

  function index_mapped;
    input [21:0] idx;
    begin
      case (idx)
        `IDX_BUS_EVENT_STATUS, `IDX_EP_ZERO_STATUS, `IDX_BUS_EVENT_CLEAR,
        `IDX_EP_ZERO_CLEAR, `IDX_IRQ_MASK_BUS, `IDX_IRQ_MASK_EP0,
        `IDX_NAK_CONTROL: index_mapped = 1'b1;
        default: index_mapped = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] ep0_status_reg;
  reg [7:0] ep0_status_next;
  reg [7:0] bus_status_reg;
  reg [7:0] bus_status_next;
  reg [7:0] mask_ep0_reg;
  reg [7:0] mask_bus_reg;
  reg [7:0] nak_ctrl_reg;
  reg [7:0] nak_ctrl_next;
  reg [7:0] ep0_clear_reg;
  reg [7:0] bus_clear_reg;

  // write channel: address and data taken in either order
  reg aw_held_reg;
  reg w_held_reg;
  reg [21:0] aw_idx_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire wr_fire;
  wire lane0;
  wire [7:0] wbyte;

  assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign lane0 = w_strb_reg[0];
  assign wbyte = w_data_reg[7:0];

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 22'h000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_held_reg && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= word_index(S_AXI_AWADDR);
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (!index_mapped(aw_idx_reg)) begin
          S_AXI_BRESP <= `RESP_DECERR;
        end else if (aw_idx_reg == `IDX_EP_ZERO_STATUS ||
                     aw_idx_reg == `IDX_BUS_EVENT_STATUS) begin
          S_AXI_BRESP <= `RESP_SLVERR;
        end else begin
          S_AXI_BRESP <= `RESP_OKAY;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // one-cycle clear strobes, an all-ones byte means nothing cleared
  wire wr_ok;
  assign wr_ok = wr_fire && lane0;

  reg [7:0] mask_ep0_next;
  reg [7:0] mask_bus_next;

  // next mask values, so the request follows a mask write on the same edge
  always @* begin
    mask_ep0_next = mask_ep0_reg;
    mask_bus_next = mask_bus_reg;
    if (wr_ok && aw_idx_reg == `IDX_IRQ_MASK_EP0) begin
      mask_ep0_next = wbyte;
    end
    if (wr_ok && aw_idx_reg == `IDX_IRQ_MASK_BUS) begin
      mask_bus_next = wbyte;
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_ep0_reg <= `MASK_RESET;
      mask_bus_reg <= `MASK_RESET;
    end else begin
      mask_ep0_reg <= mask_ep0_next;
      mask_bus_reg <= mask_bus_next;
    end
  end

  always @* begin
    ep0_clear_reg = 8'hFF;
    bus_clear_reg = 8'hFF;
    if (wr_ok && aw_idx_reg == `IDX_EP_ZERO_CLEAR) begin
      ep0_clear_reg = wbyte;
    end
    if (wr_ok && aw_idx_reg == `IDX_BUS_EVENT_CLEAR) begin
      bus_clear_reg = wbyte;
    end
  end

  // transmit arming and IN-token answer
  reg tx_fire;
  reg nak_fire;
  wire fw_nak_write;
  assign fw_nak_write = wr_ok && aw_idx_reg == `IDX_NAK_CONTROL;

  always @* begin
    nak_ctrl_next = nak_ctrl_reg;
    tx_fire = 1'b0;
    nak_fire = 1'b0;
    if (fw_nak_write) begin
      nak_ctrl_next = wbyte;
    end
    if (IN_TOKEN) begin
      if (nak_ctrl_reg[0]) begin
        tx_fire = 1'b1;
        nak_ctrl_next[0] = 1'b0;
      end else begin
        nak_fire = 1'b1;
      end
    end
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      nak_ctrl_reg <= `NAK_CTRL_RESET;
      TX_SEND <= 1'b0;
      IN_NAK <= 1'b0;
    end else begin
      nak_ctrl_reg <= nak_ctrl_next;
      TX_SEND <= tx_fire;
      IN_NAK <= nak_fire;
    end
  end

  // status update: hardware set wins over any clear in the same cycle
  reg [7:0] ep0_set;
  reg [7:0] ep0_hw_clr;

  always @* begin
    ep0_set = 8'h00;
    ep0_hw_clr = 8'h00;
    ep0_set[`BIT_IN_NAK] = nak_fire;
    ep0_set[`BIT_TX_DONE] = TX_DONE_EVT;
    ep0_set[`BIT_RX_DATA] = RX_DATA_EVT && !RX_IS_NULL;
    ep0_set[`BIT_XFER_SUCCESS] = STATUS_OK_EVT;
    ep0_set[`BIT_STATUS_STAGE] = STATUS_STAGE_EVT;
    ep0_set[`BIT_SETUP_SEEN] = SETUP_DATA_EVT;
    ep0_set[`BIT_FW_DECODE] = FW_DECODE_EVT;
    ep0_hw_clr[`BIT_TX_DONE] = TX_BUF_WRITE;
    ep0_hw_clr[`BIT_RX_DATA] = RX_EMPTIED;
    ep0_hw_clr[`BIT_XFER_SUCCESS] = SETUP_TOKEN;
    ep0_hw_clr[`BIT_STATUS_STAGE] = SETUP_TOKEN;
    ep0_hw_clr[`BIT_FW_DECODE] = SETUP_BUF_READ_DONE;
    // zero in clear byte clears bit
    ep0_status_next = ep0_set | (ep0_status_reg & ep0_clear_reg & ~ep0_hw_clr);
    ep0_status_next[`BIT_UNUSED] = 1'b0;
    bus_status_next = BUS_EVT | (bus_status_reg & bus_clear_reg);
  end

  wire ep0_pending;
  wire bus_pending;
  assign ep0_pending = |(ep0_status_next & mask_ep0_next);
  assign bus_pending = |(bus_status_next & mask_bus_next);

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ep0_status_reg <= `STATUS_RESET;
      bus_status_reg <= `STATUS_RESET;
      USB_SHARED_IRQ <= 1'b0;
    end else begin
      ep0_status_reg <= ep0_status_next;
      bus_status_reg <= bus_status_next;
      // level OR of every pending source
      USB_SHARED_IRQ <= ep0_pending | bus_pending;
    end
  end

  // read channel
  reg [7:0] rd_byte;
  reg rd_hit;
  wire [21:0] ar_idx;
  assign ar_idx = word_index(S_AXI_ARADDR);

  always @* begin
    rd_hit = 1'b1;
    case (ar_idx)
      `IDX_EP_ZERO_STATUS: rd_byte = ep0_status_reg;
      `IDX_BUS_EVENT_STATUS: rd_byte = bus_status_reg;
      `IDX_IRQ_MASK_EP0: rd_byte = mask_ep0_reg;
      `IDX_IRQ_MASK_BUS: rd_byte = mask_bus_reg;
      `IDX_NAK_CONTROL: rd_byte = nak_ctrl_reg;
      `IDX_EP_ZERO_CLEAR, `IDX_BUS_EVENT_CLEAR: rd_byte = 8'h00;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h000000, rd_byte};
        S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> ep_zero_irq_consts.vh
`ifndef EP_ZERO_IRQ_CONSTS_VH
`define EP_ZERO_IRQ_CONSTS_VH

// register indexes; byte address is four times the index
`define IDX_BUS_EVENT_STATUS 22'h0F0550
`define IDX_EP_ZERO_STATUS 22'h0F0551
`define IDX_BUS_EVENT_CLEAR 22'h0F0560
`define IDX_EP_ZERO_CLEAR 22'h0F0561
`define IDX_IRQ_MASK_BUS 22'h0F0568
`define IDX_IRQ_MASK_EP0 22'h0F0569
`define IDX_NAK_CONTROL 22'h0F0570

// ep_zero_irq_status bit positions
`define BIT_FW_DECODE 0
`define BIT_SETUP_SEEN 1
`define BIT_STATUS_STAGE 2
`define BIT_XFER_SUCCESS 3
`define BIT_RX_DATA 4
`define BIT_TX_DONE 5
`define BIT_IN_NAK 6
`define BIT_UNUSED 7

// reset values
`define STATUS_RESET 8'h00
`define MASK_RESET 8'hFF
`define NAK_CTRL_RESET 8'h00

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// >>> ep0_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ep0_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] dly,
  input wire logic [19:0] req,
  output logic [19:0] ev
);
  logic [2:0] cnt_reg = 3'h0;
  initial ev = 20'h0;
  // single-cycle token pulses, dly+1 cycles after go
  always @(posedge clk) begin
    ev <= 20'h0;
    if (go)
      cnt_reg <= {1'b0, dly} + 3'h1;
    else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1)
        ev <= req;
    end
  end
endmodule
`default_nettype wire

// >>> ep_zero_interrupt_status_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ep_zero_interrupt_status_chk (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic IN_TOKEN,
  input wire logic TX_DONE_EVT,
  input wire logic RX_DATA_EVT,
  input wire logic STATUS_OK_EVT,
  input wire logic STATUS_STAGE_EVT,
  input wire logic SETUP_DATA_EVT,
  input wire logic FW_DECODE_EVT,
  input wire logic SETUP_TOKEN,
  input wire logic RX_EMPTIED,
  input wire logic SETUP_BUF_READ_DONE,
  input wire logic TX_BUF_WRITE,
  input wire logic TX_SEND,
  input wire logic IN_NAK,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic USB_SHARED_IRQ,
  input wire logic [7:0] BUS_EVT,
  input wire logic [31:0] S_AXI_RDATA
);
  wire set_ev = IN_TOKEN | TX_DONE_EVT | RX_DATA_EVT | STATUS_OK_EVT | STATUS_STAGE_EVT |
    SETUP_DATA_EVT | FW_DECODE_EVT | (|BUS_EVT);
  wire clr_ev = SETUP_TOKEN | RX_EMPTIED | SETUP_BUF_READ_DONE | TX_BUF_WRITE;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  property p_ans; IN_TOKEN |=> TX_SEND ^ IN_NAK; endproperty
  a_ans: assert property (p_ans) else $error("IN not answered");
  property p_quiet; !IN_TOKEN |=> !TX_SEND && !IN_NAK; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without IN");
  property p_rd8; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
  a_rd8: assert property (p_rd8) else $error("wide read data");
  property p_rise; $rose(USB_SHARED_IRQ) |-> $past(set_ev) || S_AXI_BVALID; endproperty
  a_rise: assert property (p_rise) else $error("request without cause");
  property p_fall; $fell(USB_SHARED_IRQ) |-> $past(clr_ev) || S_AXI_BVALID; endproperty
  a_fall: assert property (p_fall) else $error("request dropped");
  property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_bend; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_bend: assert property (p_bend) else $error("write answer held");
  property p_rend; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
  a_rend: assert property (p_rend) else $error("read answer held");
  c_tx: cover property (TX_SEND);
  c_nak: cover property (IN_NAK);
  c_fall: cover property ($fell(USB_SHARED_IRQ));
endmodule
bind ep_zero_interrupt_status ep_zero_interrupt_status_chk i_ep_zero_interrupt_status_chk (.*);
`default_nettype wire

// >>> ep_zero_interrupt_status_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "ep_zero_irq_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ep_zero_interrupt_status_test;
  logic REF_CLK = 0, RST_B = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0, ta, tw;
  logic [23:0] awa = 24'h0, ara = 24'h0;
  logic [31:0] wd = 32'h0, lf = 32'h5E0DA4EE, rd;
  logic [19:0] req = 20'h0, ev;
  logic [1:0] dly = 2'h0, rs;
  logic [7:0] ms = 8'h00, bs = 8'h00, m0 = 8'hFF, m1 = 8'hFF, nk = 8'h00, v;
  wire awr, wrr, bv, arr, rv, txs, nak, irq;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  int n_errors = 0, samples_checked = 0, k, s, ntx = 0, nnk = 0, etx = 0, enk = 0;
  ep0_host_model i_ep0_host_model (.clk(REF_CLK), .go(go), .dly(dly), .req(req), .ev(ev));
  ep_zero_interrupt_status i_ep_zero_interrupt_status (.REF_CLK(REF_CLK), .RST_B(RST_B),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .IN_TOKEN(ev[0]), .TX_DONE_EVT(ev[1]), .TX_BUF_WRITE(ev[2]),
    .RX_DATA_EVT(ev[3]), .RX_IS_NULL(ev[4]), .RX_EMPTIED(ev[5]), .STATUS_OK_EVT(ev[6]),
    .STATUS_STAGE_EVT(ev[7]), .SETUP_TOKEN(ev[8]), .SETUP_DATA_EVT(ev[9]),
    .FW_DECODE_EVT(ev[10]), .SETUP_BUF_READ_DONE(ev[11]), .BUS_EVT(ev[19:12]),
    .TX_SEND(txs), .IN_NAK(nak), .USB_SHARED_IRQ(irq));
  initial forever #10 REF_CLK = ~REF_CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // pulses stand for one whole cycle, so count them away from the launching edge
  always @(negedge REF_CLK) begin
    ntx += (txs === 1'b1);
    nnk += (nak === 1'b1);
  end
  task test_done;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick;
    k++;
    if (k > 300) begin
      n_errors++;
      test_done;
    end
  endtask
  // channel c: 0 read address, 1 write response, 2 read data
  task hs(input int c);
    k = 0;
    do begin
      @(negedge REF_CLK);
      tick;
    end while ((c == 0 ? arr : c == 1 ? bv : rv) !== 1'b1);
    rd = rdt;
    rs = c == 1 ? br : rr;
    @(posedge REF_CLK);
  endtask
  task wr(input [21:0] i, input [7:0] d);
    awa <= {i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    k = 0;
    ta = 1'b0;
    tw = 1'b0;
    // address and data may be taken at different edges
    while (!(ta && tw)) begin
      @(negedge REF_CLK);
      tick;
      ta = ta | awr;
      tw = tw | wrr;
      @(posedge REF_CLK);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bry <= 1'b1;
    hs(1);
    bry <= 1'b0;
  endtask
  task rdr(input [21:0] i);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    hs(0);
    arv <= 1'b0;
    rry <= 1'b1;
    hs(2);
    rry <= 1'b0;
  endtask
  task cmp;
    rdr(`IDX_EP_ZERO_STATUS); `CHK(rd, {24'h0, ms})
    rdr(`IDX_BUS_EVENT_STATUS); `CHK(rd, {24'h0, bs})
    rdr(`IDX_NAK_CONTROL); `CHK(rd, {24'h0, nk})
    @(negedge REF_CLK); `CHK(irq, |(ms & m0) | |(bs & m1))
    @(posedge REF_CLK);
  endtask
  task fe(input int b, input logic nul);
    req <= (20'h1 << b) | {15'h0, nul & (b == 3), 4'h0};
    dly <= lf[1:0];
    go <= 1'b1;
    @(posedge REF_CLK);
    go <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    case (b)
      0: if (nk[0]) begin nk = 8'h00; etx++; end else begin ms |= 8'h40; enk++; end
      1: ms |= 8'h20;
      2: ms &= 8'hDF;
      3: if (!nul) ms |= 8'h10;
      5: ms &= 8'hEF;
      6: ms |= 8'h08;
      7: ms |= 8'h04;
      8: ms &= 8'hF3;
      9: ms |= 8'h02;
      10: ms |= 8'h01;
      11: ms &= 8'hFE;
      default: bs |= 8'h1 << (b - 12);
    endcase
  endtask
  initial begin
    repeat (20) @(posedge REF_CLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    rdr(`IDX_IRQ_MASK_EP0); `CHK(rd, 32'hFF)
    rdr(22'h000001); `CHK(rs, `RESP_DECERR)
    wr(`IDX_EP_ZERO_STATUS, 8'h7F); `CHK(rs, `RESP_SLVERR)
    cmp;
    $display("done access");
    for (int n = 0; n < 150; n++) begin
      lf = lfsr(lf);
      s = lf[4:0];
      v = lf[15:8] | lf[23:16];
      if (s < 20) fe(s == 4 ? 3 : s, lf[9]);
      else if (s < 23) begin wr(`IDX_EP_ZERO_CLEAR, v); ms &= v; end
      else if (s < 25) begin wr(`IDX_BUS_EVENT_CLEAR, v); bs &= v; end
      else if (s < 27) begin wr(`IDX_NAK_CONTROL, 8'h01); nk = 8'h01; end
      else if (s < 29) begin wr(`IDX_IRQ_MASK_EP0, v); m0 = v; end
      else begin wr(`IDX_IRQ_MASK_BUS, v); m1 = v; end
      if (s >= 20) `CHK(rs, `RESP_OKAY)
      cmp;
    end
    `CHK(ntx, etx)
    `CHK(nnk, enk)
    $display("done events");
    for (int i = 0; i < 8; i++) begin
      if (ms[i]) begin wr(`IDX_EP_ZERO_CLEAR, ~(8'h1 << i)); ms[i] = 1'b0; end
      if (bs[i]) begin wr(`IDX_BUS_EVENT_CLEAR, ~(8'h1 << i)); bs[i] = 1'b0; end
      cmp;
    end
    $display("done handler");
    test_done;
  end
endmodule
`default_nettype wire
